//--- hdl/lss_pkg.sv
// shared constants, register map and types of the line driven set sequencer
package lss_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SETTLE_NS = 1000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W = 8;
  localparam logic [SETTLE_W-1:0] SETTLE_LOAD = 8'(SETTLE_CYC);

  // sizes
  localparam int unsigned IDX_W = 3;
  localparam int unsigned NUM_SETS = 8;
  localparam int unsigned PARAM_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_LINES = 2;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'h8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SET_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_BASE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MEM_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_MEM_DATA = 8'h1c;

  // control field: bit0 enable, bit1 advance line, bit2 restart enable, bits4:3 invert
  localparam int unsigned CTRL_LSB = 0;
  localparam int unsigned CTRL_W = 5;
  // status field positions
  localparam int unsigned ST_IDX_LSB = 0;
  localparam int unsigned ST_WAIT_BIT = 3;
  localparam int unsigned ST_EN_BIT = 4;
  localparam int unsigned ST_BUSY_BIT = 5;
  // interrupt event bits
  localparam int unsigned EV_TAKEN = 0;
  localparam int unsigned EV_DROP = 1;
  localparam int unsigned EV_CYCLE = 2;
  localparam int unsigned EV_W = 3;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [CNT_W-1:0] SET_COUNT_RST = 4'h8;
  localparam logic [EV_W-1:0] INT_MASK_RST = 3'h0;
  localparam logic [PARAM_W-1:0] BASE_RST = 32'h0000_0000;

  typedef struct packed {
    logic [NUM_LINES-1:0] inv;
    logic rst_en;
    logic adv_sel;
    logic enable;
  } lss_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } lss_bus_req_t;

  typedef enum logic [1:0] {ST_OFF, ST_LOAD, ST_RUN} lss_state_t;
endpackage

//--- hdl/lss_sync.sv
// three stage synchronisers with agreement filter for the pin inputs
`timescale 1ns/100ps
`default_nettype none
module lss_sync (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic [2:0] pin, // raw pins: trigger, line 2, line 1
  output logic [2:0] level, // filtered level
  output logic [2:0] rise, // one cycle: filtered level rises
  output logic [2:0] change, // one cycle: filtered level changes
  output logic [2:0] unstable // stages two and three disagree
);
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bit
      logic s1, s2, s3, filt, next_filt;
      always_comb begin
        next_filt = (s2 == s3) ? s3 : filt;
      end
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          filt <= 1'b0;
        end else begin
          s1 <= pin[i];
          s2 <= s1;
          s3 <= s2;
          filt <= next_filt;
        end
      end
      assign level[i] = filt;
      assign change[i] = next_filt != filt;
      assign rise[i] = next_filt & ~filt;
      assign unstable[i] = s2 != s3;
    end
  endgenerate
endmodule // lss_sync
`default_nettype wire

//--- hdl/lss_set_mem.sv
// parameter set store with registered read data
`timescale 1ns/100ps
`default_nettype none
module lss_set_mem
  import lss_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic we, // write enable
  input wire logic [lss_pkg::IDX_W-1:0] waddr, // write index
  input wire logic [lss_pkg::PARAM_W-1:0] wdata, // write data
  input wire logic [lss_pkg::IDX_W-1:0] raddr, // read index
  output logic [lss_pkg::PARAM_W-1:0] rdata // read data, one cycle later
);
  logic [PARAM_W-1:0] mem [NUM_SETS];

  // array has no reset so it maps onto plain storage
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // lss_set_mem
`default_nettype wire

//--- hdl/lss_sequencer.sv
// line driven parameter set sequencer: set selection, registers and interrupt
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: step sets ascending, only at frame triggers
// R2: either input line may steer advance
// R3: enabling starts cycle at set zero
// R4: advance line low keeps current set
// R5: advance line high loads next set
// R6: indices run zero to count minus one
// R7: advance past last set wraps to zero
// R8: line change drops waiting, discards triggers
// R9: source triggers only while device waits
// R10: disabling restores pre-enable active parameters
// R11: other line may be restart source
// R12: restart high selects set zero, wins
// R13: restart low leaves normal advance decision
// R14: both lines sampled at every trigger
// R15: per-line invert option on control levels
module lss_sequencer
  import lss_pkg::*;
(
  input wire logic clock, // system clock, 125 MHz
  input wire logic resetn, // async reset, active low
  input wire lss_pkg::lss_bus_req_t bus_req, // register bus request
  output logic [lss_pkg::DATA_W-1:0] rdata, // read data, cycle after read strobe
  input wire logic [lss_pkg::NUM_LINES-1:0] line_pin, // input lines 1 and 2
  input wire logic trig_pin, // frame start trigger, rising edge
  output logic [lss_pkg::PARAM_W-1:0] active_params, // active parameter set
  output logic [lss_pkg::IDX_W-1:0] active_index, // current set index
  output logic waiting, // waiting for frame start trigger
  output logic capture, // one cycle: trigger accepted
  output logic irq // level interrupt
);
  import lss_pkg::*;

  logic [2:0] lvl, rise, chg, unstable;
  logic [PARAM_W-1:0] mem_rdata;
  lss_ctrl_t ctrl, next_ctrl;
  logic [CNT_W-1:0] set_count, next_set_count;
  logic [EV_W-1:0] int_stat, next_int_stat, int_mask, next_int_mask, events;
  logic [PARAM_W-1:0] base, next_base, next_active;
  logic [IDX_W-1:0] mem_addr, next_mem_addr, idx, next_idx, last;
  logic [DATA_W-1:0] next_rdata;
  logic [SETTLE_W-1:0] settle, next_settle;
  lss_state_t state, next_state;
  logic adv_hit, rst_hit, accept, busy, mem_we, adv_line, rst_line, wr_hit_int;

  lss_sync u_sync (
    .clock(clock),
    .resetn(resetn),
    .pin({trig_pin, line_pin}),
    .level(lvl),
    .rise(rise),
    .change(chg),
    .unstable(unstable)
  );

  assign mem_we = bus_req.wr && (bus_req.addr == OFF_MEM_DATA);

  lss_set_mem u_mem (
    .clock(clock),
    .resetn(resetn),
    .we(mem_we),
    .waddr(mem_addr),
    .wdata(bus_req.wdata),
    .raddr(next_idx),
    .rdata(mem_rdata)
  );

  // decision logic
  always_comb begin
    adv_line = ctrl.adv_sel; // R2
    rst_line = ~ctrl.adv_sel; // R11
    adv_hit = lvl[adv_line] ^ ctrl.inv[adv_line]; // R15
    rst_hit = ctrl.rst_en & (lvl[rst_line] ^ ctrl.inv[rst_line]); // R15
    // a zero count behaves as a single set
    last = (set_count == '0) ? '0 : IDX_W'(set_count - 4'h1); // R6
    // any line change opens a settle window; triggers in it are dropped
    busy = (settle != '0) | (|unstable[1:0]); // R8
    waiting = (state == ST_RUN) & ~busy; // R8
    accept = rise[2] & waiting; // R1 R9
    capture = accept;
    events = '0;
    events[EV_TAKEN] = accept;
    events[EV_DROP] = rise[2] & ~waiting & (state != ST_OFF); // R8
    next_state = state;
    next_idx = idx;
    next_active = active_params;
    case (state)
      ST_OFF: begin
        next_active = base; // R10
        if (ctrl.enable) begin
          next_idx = '0; // R3
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        next_active = mem_rdata;
        next_state = ST_RUN;
        if (!ctrl.enable) begin
          next_active = base; // R10
          next_state = ST_OFF;
        end
      end
      ST_RUN: begin
        if (!ctrl.enable) begin
          next_active = base; // R10
          next_state = ST_OFF;
        end else if (accept) begin // R14
          next_state = ST_LOAD;
          if (rst_hit) begin
            next_idx = '0; // R12
            events[EV_CYCLE] = 1'b1;
          end else if (adv_hit) begin // R13
            if (idx >= last) begin
              next_idx = '0; // R7
              events[EV_CYCLE] = 1'b1;
            end else begin
              next_idx = idx + 3'h1; // R1 R5
            end
          end
          // low advance line keeps the index; reload is harmless R4
        end
      end
      default: begin
        next_state = ST_OFF;
        next_active = base;
      end
    endcase
    next_settle = settle;
    if (|chg[1:0]) begin
      next_settle = SETTLE_LOAD; // R8
    end else if (settle != '0) begin
      next_settle = settle - 8'h01;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= ST_OFF;
      idx <= '0;
      active_params <= BASE_RST;
      settle <= '0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      active_params <= next_active;
      settle <= next_settle;
    end
  end

  assign active_index = idx;

  // register file
  always_comb begin
    next_ctrl = ctrl;
    next_set_count = set_count;
    next_int_mask = int_mask;
    next_base = base;
    next_mem_addr = mem_addr;
    next_rdata = '0;
    wr_hit_int = bus_req.wr && (bus_req.addr == OFF_INT_STATUS);
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFF_CTRL: next_ctrl = bus_req.wdata[CTRL_LSB +: CTRL_W];
        OFF_SET_COUNT: begin
          // counts above the store depth are clamped
          next_set_count = (bus_req.wdata[CNT_W-1:0] > CNT_MAX) ? CNT_MAX :
                           bus_req.wdata[CNT_W-1:0];
        end
        OFF_INT_MASK: next_int_mask = bus_req.wdata[EV_W-1:0];
        OFF_BASE: next_base = bus_req.wdata;
        OFF_MEM_ADDR: next_mem_addr = bus_req.wdata[IDX_W-1:0];
        default: next_base = base;
      endcase
    end
    // set wins over a write-one clear in the same cycle
    next_int_stat = (int_stat & ~(wr_hit_int ? bus_req.wdata[EV_W-1:0] : '0)) | events;
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFF_CTRL: next_rdata[CTRL_LSB +: CTRL_W] = ctrl;
        OFF_SET_COUNT: next_rdata[CNT_W-1:0] = set_count;
        OFF_STATUS: begin
          next_rdata[ST_IDX_LSB +: IDX_W] = idx;
          next_rdata[ST_WAIT_BIT] = waiting;
          next_rdata[ST_EN_BIT] = (state != ST_OFF);
          next_rdata[ST_BUSY_BIT] = busy;
        end
        OFF_INT_STATUS: next_rdata[EV_W-1:0] = int_stat;
        OFF_INT_MASK: next_rdata[EV_W-1:0] = int_mask;
        OFF_BASE: next_rdata = base;
        OFF_MEM_ADDR: next_rdata[IDX_W-1:0] = mem_addr;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= CTRL_RST;
      set_count <= SET_COUNT_RST;
      int_stat <= '0;
      int_mask <= INT_MASK_RST;
      base <= BASE_RST;
      mem_addr <= '0;
      rdata <= '0;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      set_count <= next_set_count;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      base <= next_base;
      mem_addr <= next_mem_addr;
      rdata <= next_rdata;
      irq <= |(next_int_stat & next_int_mask);
    end
  end

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  logic a_adv, a_rst;
  assign a_adv = lvl[ctrl.adv_sel] ^ ctrl.inv[ctrl.adv_sel];
  assign a_rst = ctrl.rst_en & (lvl[~ctrl.adv_sel] ^ ctrl.inv[~ctrl.adv_sel]);

  a_restart_first: assert property (accept && a_rst |=> idx == '0) // R12
    else $error("restart did not select set zero");
  a_hold_low: assert property (accept && !a_rst && !a_adv |=> $stable(idx)) // R4
    else $error("set changed with advance line low");
  a_advance_step: assert property (accept && !a_rst && a_adv && idx < last |=>
                                   idx == $past(idx) + 3'h1) // R5
    else $error("advance did not step by one");
  a_wrap_zero: assert property (accept && !a_rst && a_adv && idx >= last |=> idx == '0) // R7
    else $error("advance from last set did not wrap");
  a_enable_zero: assert property (state == ST_OFF && ctrl.enable |=>
                                  idx == '0 ##1 state == ST_RUN) // R3
    else $error("enable did not start at set zero");
  a_disable_base: assert property (state != ST_OFF && !ctrl.enable ##1 !ctrl.enable |->
                                   active_params == $past(base)) // R10
    else $error("disable did not restore base parameters");
  a_discard_busy: assert property (rise[2] && busy |-> !capture ##1 $stable(idx)) // R8
    else $error("trigger taken during line change");
  a_index_range: assert property (accept |=> idx <= $past(last)) // R6
    else $error("index beyond set count");
  a_no_idle_step: assert property (!accept && state == ST_RUN |=> $stable(idx)) // R1
    else $error("index moved without trigger");
  a_settle_len: assert property (|chg[1:0] |=> busy [*8]) // R8
    else $error("settle window too short");

  c_restart: cover property (accept && a_rst && idx != '0);
  c_wrap: cover property (accept && !a_rst && a_adv && idx == last && last != '0);
  c_discard: cover property (rise[2] && busy && state == ST_RUN);
  c_hold: cover property (accept && !a_rst && !a_adv);
endmodule // lss_sequencer
`default_nettype wire

//--- verification/lss_line_src.sv
// model of the external trigger logic driving the lines and frame trigger
`timescale 1ns/100ps
`default_nettype none
module lss_line_src (
  input wire logic clock, // system clock
  input wire logic waiting, // device waiting for trigger
  output logic [1:0] line_pin, // input lines 1 and 2
  output logic trig_pin // frame start trigger
);
  initial begin
    line_pin = 2'h0;
    trig_pin = 1'b0;
  end
  // early fires inside the settle window on purpose, to be dropped
  task automatic fire(input logic [1:0] lines, input bit early, output bit ok);
    int n;
    ok = 1'b1;
    @(posedge clock);
    line_pin <= lines;
    if (early) begin
      repeat (6) @(posedge clock);
    end else begin
      repeat (140) @(posedge clock);
      ok = 1'b0;
      for (n = 0; n < 400 && !ok; n++) begin
        @(negedge clock);
        ok = (waiting === 1'b1);
      end
    end
    @(posedge clock);
    trig_pin <= 1'b1;
    repeat (8) @(posedge clock);
    trig_pin <= 1'b0;
    // lines held a full settle time after a normal trigger, only eight cycles after an early one
    repeat (early ? 8 : 130) @(posedge clock);
  endtask
endmodule // lss_line_src
`default_nettype wire

//--- verification/lss_sequencer_tb.sv
// self-checking bench of the line driven set sequencer
`timescale 1ns/100ps
`default_nettype none
module lss_sequencer_tb;
  import lss_pkg::*;
  localparam logic [9:0] PAT = 10'b1011110010;
  logic clock;
  logic resetn;
  lss_bus_req_t bus_req;
  logic [DATA_W-1:0] rdata;
  logic [NUM_LINES-1:0] line_pin;
  logic trig_pin;
  logic [PARAM_W-1:0] active_params;
  logic [IDX_W-1:0] active_index;
  logic waiting;
  logic capture;
  logic irq;
  int mismatches = 0;
  int checks = 0;
  int caps = 0;
  int exp_idx;
  int c0;
  logic [4:0] ctl;
  logic [31:0] d;
  bit ok;
  logic [1:0] rseq [5] = '{2'h1, 2'h1, 2'h3, 2'h2, 2'h1};

  lss_sequencer DUT (.clock(clock), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
    .line_pin(line_pin), .trig_pin(trig_pin), .active_params(active_params),
    .active_index(active_index), .waiting(waiting), .capture(capture), .irq(irq));
  lss_line_src src (.clock(clock), .waiting(waiting), .line_pin(line_pin),
    .trig_pin(trig_pin));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    if (capture === 1'b1) caps++;
  end
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    end_sim;
  end

  task automatic end_sim;
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    bus_req <= '{1'b1, 1'b0, a, v};
    @(posedge clock);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clock);
    bus_req <= '0;
    #1 v = rdata;
  endtask
  task automatic en(input logic [4:0] c);
    ctl = c;
    exp_idx = 0;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CTRL, 32'(c));
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("index", 32'h0, 32'(active_index));
    chk("params", 32'h5e70_0000, active_params);
  endtask
  // expected set follows restart priority, then advance with wrap at count six
  task automatic trig(input logic [1:0] lines);
    int s;
    bit adv;
    bit rs;
    s = int'(ctl[1]);
    c0 = caps;
    adv = lines[s] ^ ctl[3 + s];
    rs = ctl[2] & (lines[1 - s] ^ ctl[4 - s]);
    exp_idx = rs ? 0 : !adv ? exp_idx : (exp_idx == 5) ? 0 : exp_idx + 1;
    src.fire(lines, 1'b0, ok);
    if (!ok) begin
      mismatches++;
      end_sim;
    end
    @(negedge clock);
    chk("index", 32'(exp_idx), 32'(active_index));
    chk("params", 32'h5e70_0000 + 32'(exp_idx), active_params);
    chk("captures", 32'(c0 + 1), 32'(caps));
  endtask

  initial begin
    resetn = 1'b0;
    bus_req = '0;
    ctl = '0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    rd(OFF_SET_COUNT, d);
    chk("set_count", 32'h8, d);
    rd(OFF_CTRL, d);
    chk("ctrl", 32'h0, d);
    rd(8'h20, d);
    chk("unmapped", 32'h0, d);
    wr(OFF_BASE, 32'hb0b0_0001);
    rd(OFF_BASE, d);
    chk("base", 32'hb0b0_0001, d);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_MEM_ADDR, 32'(i));
      wr(OFF_MEM_DATA, 32'h5e70_0000 + 32'(i));
    end
    wr(OFF_SET_COUNT, 32'h6);
    for (int s = 0; s < 2; s++) begin
      en(5'h1 | 5'(s << 1));
      for (int i = 0; i < 10; i++) begin
        trig(PAT[i] ? 2'(1 << s) : 2'h0);
      end
      wr(OFF_CTRL, 32'h0);
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk("params", 32'hb0b0_0001, active_params);
      c0 = caps;
      src.fire(2'h0, 1'b1, ok);
      chk("captures", 32'(c0), 32'(caps));
    end
    en(5'b00101);
    foreach (rseq[i]) begin
      trig(rseq[i]);
    end
    // trigger sent while the line is still settling must be discarded
    c0 = caps;
    src.fire(2'h0, 1'b1, ok);
    chk("waiting", 32'h0, 32'(waiting));
    chk("captures", 32'(c0), 32'(caps));
    chk("index", 32'h1, 32'(active_index));
    rd(OFF_STATUS, d);
    chk("status", 32'h31, d);
    rd(OFF_INT_STATUS, d);
    chk("int_status", 32'h7, d);
    en(5'b01001);
    trig(2'h0);
    trig(2'h1);
    trig(2'h0);
    wr(OFF_INT_MASK, 32'h0);
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("irq", 32'h0, 32'(irq));
    wr(OFF_INT_MASK, 32'h4);
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("irq", 32'h1, 32'(irq));
    wr(OFF_INT_STATUS, 32'h7);
    rd(OFF_INT_STATUS, d);
    chk("int_status", 32'h0, d);
    chk("irq", 32'h0, 32'(irq));
    end_sim;
  end
endmodule // lss_sequencer_tb
`default_nettype wire
